// File: instruction_opcode_decoder_test.sv
// Self-checking testbench for the instruction decoder.
`timescale 1ns/1ps
`default_nettype none

module instruction_opcode_decoder_test;
  logic             ref_clk_i;
  logic             resetn_i;
  logic             valid_i;
  logic [31:0]      instr_i;
  logic             valid_o;
  iod_pkg::iod_op_t op_o;
  logic [3:0]       cond_o;
  logic             set_cc_o;
  logic             alt_space_o;
  logic [8:0]       fp_subop_o;
  logic [29:0]      call_disp_o;
  logic             unimp_o;
  int               n_mismatch = 0;
  int               checked = 0;
  logic [5:0]       t_code [40] = '{6'h08, 6'h0c, 6'h18, 6'h1c, 6'h0a, 6'h0b, 6'h1a, 6'h1b,
    6'h1d, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h29, 6'h2a, 6'h2b, 6'h2c,
    6'h31, 6'h32, 6'h33, 6'h38, 6'h39, 6'h3c, 6'h3d, 6'h0e, 6'h0f, 6'h1e, 6'h1f, 6'h34, 6'h35,
    6'h36, 6'h37, 6'h3b, 6'h09, 6'h2d, 6'h3e};
  iod_pkg::iod_op_t t_op [40] = '{iod_pkg::IOD_OP_ADDX, iod_pkg::IOD_OP_SUBX,
    iod_pkg::IOD_OP_ADDX, iod_pkg::IOD_OP_SUBX, iod_pkg::IOD_OP_UNSIGNED_MULTIPLY, iod_pkg::IOD_OP_SIGNED_MULTIPLY,
    iod_pkg::IOD_OP_UNSIGNED_MULTIPLY, iod_pkg::IOD_OP_SIGNED_MULTIPLY, iod_pkg::IOD_OP_DIVIDE_STEP,
    iod_pkg::IOD_OP_TADD, iod_pkg::IOD_OP_TSUB, iod_pkg::IOD_OP_TADD_TV,
    iod_pkg::IOD_OP_TSUB_TV, iod_pkg::IOD_OP_MULTIPLY_STEP, iod_pkg::IOD_OP_SHIFT_LEFT_LOGICAL,
    iod_pkg::IOD_OP_SHIFT_RIGHT_LOGICAL, iod_pkg::IOD_OP_SHIFT_RIGHT_ARITH,
    iod_pkg::IOD_OP_READ_PROCESSOR_STATE, iod_pkg::IOD_OP_READ_WINDOW_INVALID_MASK,
    iod_pkg::IOD_OP_READ_TRAP_BASE, iod_pkg::IOD_OP_BIT_SCAN,
    iod_pkg::IOD_OP_WRITE_PROCESSOR_STATE, iod_pkg::IOD_OP_WRITE_WINDOW_INVALID_MASK,
    iod_pkg::IOD_OP_WRITE_TRAP_BASE, iod_pkg::IOD_OP_JUMP_AND_LINK,
    iod_pkg::IOD_OP_RETURN_FROM_TRAP, iod_pkg::IOD_OP_SAVE, iod_pkg::IOD_OP_RESTORE,
    iod_pkg::IOD_OP_UDIV, iod_pkg::IOD_OP_SDIV, iod_pkg::IOD_OP_UDIV, iod_pkg::IOD_OP_SDIV,
    iod_pkg::IOD_OP_FLOAT_OPERATE, iod_pkg::IOD_OP_FLOAT_COMPARE,
    iod_pkg::IOD_OP_COPROC_OPERATE_ONE, iod_pkg::IOD_OP_COPROC_OPERATE_TWO,
    iod_pkg::IOD_OP_FLUSH, iod_pkg::IOD_OP_ILLEGAL, iod_pkg::IOD_OP_ILLEGAL,
    iod_pkg::IOD_OP_ILLEGAL};
  iod_pkg::iod_op_t alu [8] = '{iod_pkg::IOD_OP_ADD, iod_pkg::IOD_OP_AND, iod_pkg::IOD_OP_OR,
    iod_pkg::IOD_OP_XOR, iod_pkg::IOD_OP_SUB, iod_pkg::IOD_OP_ANDN, iod_pkg::IOD_OP_ORN,
    iod_pkg::IOD_OP_XNOR};
  iod_pkg::iod_op_t mem [12] = '{iod_pkg::IOD_OP_LOAD_WORD, iod_pkg::IOD_OP_LOAD_UBYTE,
    iod_pkg::IOD_OP_LOAD_UHALF, iod_pkg::IOD_OP_LOAD_DOUBLE, iod_pkg::IOD_OP_STORE_WORD,
    iod_pkg::IOD_OP_STORE_BYTE, iod_pkg::IOD_OP_STORE_HALF, iod_pkg::IOD_OP_STORE_DOUBLE,
    iod_pkg::IOD_OP_LOAD_SBYTE, iod_pkg::IOD_OP_LOAD_SHALF,
    iod_pkg::IOD_OP_ATOMIC_LOAD_STORE_BYTE, iod_pkg::IOD_OP_SWAP};
  logic [5:0]       mem_code [12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
    6'h09, 6'h0a, 6'h0d, 6'h0f};

  iod_fetch_model fetch (.ref_clk_i(ref_clk_i), .valid_o(valid_i), .instr_o(instr_i));
  iod_decoder dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .valid_i(valid_i), .instr_i(instr_i),
    .valid_o(valid_o), .op_o(op_o), .cond_o(cond_o), .set_cc_o(set_cc_o),
    .alt_space_o(alt_space_o), .fp_subop_o(fp_subop_o), .call_disp_o(call_disp_o),
    .unimp_o(unimp_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] mk(input logic [1:0] f, input logic [4:0] rd,
                                     input logic [5:0] o3, input logic [18:0] lo);
    return {f, rd, o3, lo};
  endfunction : mk

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  // Checks every output 1 ns after the edge that registers the word; set_cc_o only when no trap is expected.
  task automatic issue(input logic [31:0] w, input iod_pkg::iod_op_t eop, input logic eu);
    logic [5:0] o3;
    o3 = w[24:19];
    fetch.put(w, 1'b1);
    @(posedge ref_clk_i);
    #1;
    cmp("op", 32'(eop), 32'(op_o));
    cmp("unimp", {31'h0, eu}, {31'h0, unimp_o});
    cmp("valid", 32'h0000_0001, {31'h0, valid_o});
    cmp("cond", (w[30] == 1'b0) ? {28'h0, w[28:25]} : 32'h0000_0000, {28'h0, cond_o});
    cmp("disp", (w[31:30] == 2'h1) ? {2'h0, w[29:0]} : 32'h0000_0000, {2'h0, call_disp_o});
    cmp("subop", (w[31:30] == 2'h2 && o3[5:1] == 5'h1a) ? {23'h0, w[13:5]} : 32'h0000_0000,
        {23'h0, fp_subop_o});
    cmp("alt", {31'h0, w[31:30] == 2'h3 && o3[5:4] == 2'h1}, {31'h0, alt_space_o});
    if (!eu) begin
      cmp("setcc", {31'h0, w[31:30] == 2'h2 && (o3[5] ? o3 <= 6'h24 : o3[4])},
          {31'h0, set_cc_o});
    end
  endtask : issue

  task automatic t_branch();
    logic [3:0] c;
    issue(mk(2'h0, 5'h15, 6'h25, 19'h1_2345), iod_pkg::IOD_OP_SETHI, 1'b0);
    issue(mk(2'h0, 5'h00, 6'h27, 19'h7_ffff), iod_pkg::IOD_OP_NOP, 1'b0);
    issue(mk(2'h0, 5'h03, 6'h0f, 19'h0_0001), iod_pkg::IOD_OP_ILLEGAL, 1'b1);
    issue(mk(2'h0, 5'h07, 6'h01, 19'h0_0010), iod_pkg::IOD_OP_UNIMP, 1'b0);
    issue(mk(2'h0, 5'h09, 6'h12, 19'h0_0040), iod_pkg::IOD_OP_BICC, 1'b0);
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      issue(mk(2'h0, {c[0], c}, 6'h33, 19'h2_aaaa), iod_pkg::IOD_OP_FBRANCH, 1'b0);
      issue(mk(2'h0, {~c[0], c}, 6'h3c, 19'h5_5555), iod_pkg::IOD_OP_CBRANCH, 1'b1);
      issue(mk(2'h2, {c[1], c}, 6'h3a, 19'h0_2003), iod_pkg::IOD_OP_TRAP_COND, 1'b0);
    end
    issue(32'h4000_0000, iod_pkg::IOD_OP_CALL, 1'b0);
    issue(32'h7fff_ffff, iod_pkg::IOD_OP_CALL, 1'b0);
  endtask : t_branch

  task automatic t_arith();
    for (int i = 0; i < 16; i++) begin
      issue(mk(2'h2, 5'h0a, {1'b0, i[3], 1'b0, i[2:0]}, 19'h1_4321), alu[i % 8], 1'b0);
    end
    for (int i = 0; i < 40; i++) begin
      issue(mk(2'h2, 5'h0b, t_code[i], 19'h2_b5a0), t_op[i], i >= 28);
    end
    issue(mk(2'h2, 5'h0b, 6'h28, 19'h0_0000), iod_pkg::IOD_OP_READ_MULTIPLY_DIVIDE_REG, 1'b0);
    issue(mk(2'h2, 5'h0b, 6'h28, 19'h1_c000), iod_pkg::IOD_OP_READ_ANCILLARY_STATE, 1'b0);
    issue(mk(2'h2, 5'h00, 6'h28, 19'h0_0000), iod_pkg::IOD_OP_STORE_BARRIER, 1'b1);
    issue(mk(2'h2, 5'h00, 6'h30, 19'h0_4000), iod_pkg::IOD_OP_WRITE_MULTIPLY_DIVIDE_REG, 1'b0);
    issue(mk(2'h2, 5'h11, 6'h30, 19'h0_4000), iod_pkg::IOD_OP_WRITE_ANCILLARY_STATE, 1'b0);
  endtask : t_arith

  task automatic t_mem();
    for (int i = 0; i < 12; i++) begin
      issue(mk(2'h3, 5'h05, mem_code[i], 19'h3_0f0f), mem[i], 1'b0);
      issue(mk(2'h3, 5'h05, mem_code[i] | 6'h10, 19'h3_0f0f), mem[i], 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      issue(mk(2'h3, 5'h1f, 6'h20 + i[5:0], 19'h0_0000), iod_pkg::IOD_OP_FLOAT_MEM, 1'b1);
    end
    for (int i = 0; i < 7; i++) begin
      issue(mk(2'h3, 5'h1f, 6'h30 + i[5:0], 19'h0_0000), iod_pkg::IOD_OP_COPROC_MEM, 1'b1);
    end
    issue(mk(2'h3, 5'h02, 6'h08, 19'h0_0000), iod_pkg::IOD_OP_ILLEGAL, 1'b1);
    issue(mk(2'h3, 5'h02, 6'h37, 19'h0_0000), iod_pkg::IOD_OP_ILLEGAL, 1'b1);
  endtask : t_mem

  // An unvalidated word, a back-to-back pair and a reset in mid-stream.
  task automatic t_stream();
    fetch.put(mk(2'h0, 5'h03, 6'h0f, 19'h0_0000), 1'b0);
    @(posedge ref_clk_i);
    #1;
    cmp("unimp", 32'h0000_0000, {31'h0, unimp_o});
    cmp("valid", 32'h0000_0000, {31'h0, valid_o});
    fetch.put(32'h0100_0000, 1'b1);
    fetch.put(mk(2'h2, 5'h00, 6'h3b, 19'h0_0000), 1'b1);
    #1;
    cmp("op", 32'(iod_pkg::IOD_OP_NOP), 32'(op_o));
    @(posedge ref_clk_i);
    #1;
    cmp("op", 32'(iod_pkg::IOD_OP_FLUSH), 32'(op_o));
    cmp("unimp", 32'h0000_0001, {31'h0, unimp_o});
    resetn_i <= 1'b0;
    #1;
    cmp("op", 32'(iod_pkg::IOD_OP_ILLEGAL), 32'(op_o));
    cmp("unimp", 32'h0000_0000, {31'h0, unimp_o});
    fetch.idle();
    resetn_i <= 1'b1;
    issue(mk(2'h1, 5'h0c, 6'h00, 19'h0_0001), iod_pkg::IOD_OP_CALL, 1'b0);
  endtask : t_stream

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // A hung run counts as a mismatch and still reaches the report.
  initial begin
    #2_000_000;
    n_mismatch++;
    conclude();
  end

  initial begin
    resetn_i = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_branch();
    t_arith();
    t_mem();
    t_stream();
    fetch.idle();
    conclude();
  end
endmodule : instruction_opcode_decoder_test
`default_nettype wire

// File: iod_cfg.svh
// Opcode field positions and operation codes for the instruction decoder.
`ifndef IOD_CFG_SVH
`define IOD_CFG_SVH

`define IOD_FMT_HI        31
`define IOD_FMT_LO        30
`define IOD_RD_HI         29
`define IOD_RD_LO         25
`define IOD_OP3_HI        24
`define IOD_OP3_LO        19
`define IOD_RS1_HI        18
`define IOD_RS1_LO        14
`define IOD_OPF_HI        13
`define IOD_OPF_LO        5

`define IOD_FMT_BRANCH    2'h0
`define IOD_FMT_CALL      2'h1
`define IOD_FMT_ARITH     2'h2
`define IOD_FMT_MEM       2'h3

`define IOD_OP2_UNIMP     3'h0
`define IOD_OP2_ICC       3'h2
`define IOD_OP2_SETHI     3'h4
`define IOD_OP2_FBR       3'h6
`define IOD_OP2_CBR       3'h7

`define IOD_OP3_ADDX      6'h08
`define IOD_OP3_UNSIGNED_MULTIPLY      6'h0a
`define IOD_OP3_SIGNED_MULTIPLY      6'h0b
`define IOD_OP3_SUBX      6'h0c
`define IOD_OP3_UDIV      6'h0e
`define IOD_OP3_SDIV      6'h0f
`define IOD_OP3_DIVSTEP   6'h1d
`define IOD_OP3_TADD      6'h20
`define IOD_OP3_TSUB      6'h21
`define IOD_OP3_TADDTV    6'h22
`define IOD_OP3_TSUBTV    6'h23
`define IOD_OP3_MULSTEP   6'h24
`define IOD_OP3_SHL       6'h25
`define IOD_OP3_SHRL      6'h26
`define IOD_OP3_SHRA      6'h27
`define IOD_OP3_READ_ANCILLARY_STATE     6'h28
`define IOD_OP3_READ_PROCESSOR_STATE     6'h29
`define IOD_OP3_READ_WINDOW_INVALID_MASK     6'h2a
`define IOD_OP3_READ_TRAP_BASE     6'h2b
`define IOD_OP3_SCAN      6'h2c
`define IOD_OP3_WRITE_ANCILLARY_STATE     6'h30
`define IOD_OP3_WRPSR     6'h31
`define IOD_OP3_WRWIM     6'h32
`define IOD_OP3_WRTBR     6'h33
`define IOD_OP3_FPOP1     6'h34
`define IOD_OP3_FPOP2     6'h35
`define IOD_OP3_COPROC_OPERATE_ONE     6'h36
`define IOD_OP3_CPOP2     6'h37
`define IOD_OP3_JMPL      6'h38
`define IOD_OP3_RETURN_FROM_TRAP      6'h39
`define IOD_OP3_TICC      6'h3a
`define IOD_OP3_FLUSH     6'h3b
`define IOD_OP3_SAVE      6'h3c
`define IOD_OP3_RESTORE   6'h3d

`define IOD_CC_NEVER      4'h0
`define IOD_CC_ALWAYS     4'h8

`endif

// File: iod_decoder.sv
// Registered opcode classifier for the integer core fetch-to-execute path.
`timescale 1ns/1ps
`default_nettype none
`include "iod_cfg.svh"

module iod_decoder (
  input  wire logic          ref_clk_i,     // Core clock, 40 MHz.
  input  wire logic          resetn_i,      // Asynchronous reset, active low.
  input  wire logic          valid_i,       // Instruction word valid.
  input  wire logic [31:0]   instr_i,       // Fetched instruction word.
  output logic               valid_o,       // Decoded result valid.
  output iod_pkg::iod_op_t   op_o,          // Operation class.
  output logic [3:0]         cond_o,        // Branch or trap condition.
  output logic               set_cc_o,      // Operation sets condition codes.
  output logic               alt_space_o,   // Alternate address space access.
  output logic [8:0]         fp_subop_o,    // Floating operate sub-opcode.
  output logic [29:0]        call_disp_o,   // Call displacement.
  output logic               unimp_o        // Unimplemented-instruction trap.
);

  logic [1:0]        fmt;
  logic [4:0]        rd_f;
  logic [5:0]        op3;
  logic [4:0]        rs1_f;
  logic [8:0]        opf;
  iod_pkg::iod_op_t  mem_op;
  logic              mem_alt;
  logic              mem_unimp;

  iod_pkg::iod_op_t  op_r, op_nxt;
  logic              valid_r, valid_nxt;
  logic [3:0]        cond_r, cond_nxt;
  logic              set_cc_r, set_cc_nxt;
  logic              alt_r, alt_nxt;
  logic [8:0]        opf_r, opf_nxt;
  logic [29:0]       disp_r, disp_nxt;
  logic              unimp_r, unimp_nxt;

  // Opcode families 0 to 7 of format 10, shared by the plain and cc forms.
  function automatic iod_pkg::iod_op_t alu_op(input logic [2:0] code);
    iod_pkg::iod_op_t r;
    unique case (code)
      3'h0: r = iod_pkg::IOD_OP_ADD;
      3'h1: r = iod_pkg::IOD_OP_AND;
      3'h2: r = iod_pkg::IOD_OP_OR;
      3'h3: r = iod_pkg::IOD_OP_XOR;
      3'h4: r = iod_pkg::IOD_OP_SUB;
      3'h5: r = iod_pkg::IOD_OP_ANDN;
      3'h6: r = iod_pkg::IOD_OP_ORN;
      3'h7: r = iod_pkg::IOD_OP_XNOR;
    endcase
    return r;
  endfunction : alu_op

  assign fmt   = instr_i[`IOD_FMT_HI:`IOD_FMT_LO];
  assign rd_f  = instr_i[`IOD_RD_HI:`IOD_RD_LO];
  assign op3   = instr_i[`IOD_OP3_HI:`IOD_OP3_LO];
  assign rs1_f = instr_i[`IOD_RS1_HI:`IOD_RS1_LO];
  assign opf   = instr_i[`IOD_OPF_HI:`IOD_OPF_LO];

  iod_mem_class u_mem (
    .op3_i   (op3),
    .op_o    (mem_op),
    .alt_o   (mem_alt),
    .unimp_o (mem_unimp)
  );

  always_comb begin
    valid_nxt  = valid_i;
    op_nxt     = iod_pkg::IOD_OP_ILLEGAL;
    cond_nxt   = 4'h0;
    set_cc_nxt = 1'b0;
    alt_nxt    = 1'b0;
    opf_nxt    = 9'h000;
    disp_nxt   = 30'h0000_0000;
    unimp_nxt  = 1'b0;
    unique case (fmt)
      `IOD_FMT_BRANCH: begin
        cond_nxt = rd_f[3:0];
        unique case (op3[5:3])
          `IOD_OP2_UNIMP: op_nxt = iod_pkg::IOD_OP_UNIMP;
          `IOD_OP2_ICC:   op_nxt = iod_pkg::IOD_OP_BICC;
          `IOD_OP2_SETHI: begin
            op_nxt = (rd_f == 5'h00) ? iod_pkg::IOD_OP_NOP
                                     : iod_pkg::IOD_OP_SETHI;
          end
          `IOD_OP2_FBR: op_nxt = iod_pkg::IOD_OP_FBRANCH;
          `IOD_OP2_CBR: begin
            op_nxt    = iod_pkg::IOD_OP_CBRANCH;
            unimp_nxt = 1'b1;
          end
          default: op_nxt = iod_pkg::IOD_OP_ILLEGAL;
        endcase
      end
      `IOD_FMT_CALL: begin
        op_nxt   = iod_pkg::IOD_OP_CALL;
        disp_nxt = instr_i[29:0];
      end
      `IOD_FMT_ARITH: begin
        cond_nxt = rd_f[3:0];
        if (op3[5:4] != 2'h2 && op3[5:4] != 2'h3) begin
          set_cc_nxt = op3[4];
        end
        if (op3[5] == 1'b0 && op3[3] == 1'b0) begin
          op_nxt = alu_op(op3[2:0]);
        end else begin
          unique case (op3)
            `IOD_OP3_ADDX, 6'h18: op_nxt = iod_pkg::IOD_OP_ADDX;
            `IOD_OP3_SUBX, 6'h1c: op_nxt = iod_pkg::IOD_OP_SUBX;
            `IOD_OP3_UNSIGNED_MULTIPLY, 6'h1a: op_nxt = iod_pkg::IOD_OP_UNSIGNED_MULTIPLY;
            `IOD_OP3_SIGNED_MULTIPLY, 6'h1b: op_nxt = iod_pkg::IOD_OP_SIGNED_MULTIPLY;
            `IOD_OP3_UDIV, 6'h1e: begin
              op_nxt    = iod_pkg::IOD_OP_UDIV;
              unimp_nxt = 1'b1;
            end
            `IOD_OP3_SDIV, 6'h1f: begin
              op_nxt    = iod_pkg::IOD_OP_SDIV;
              unimp_nxt = 1'b1;
            end
            `IOD_OP3_DIVSTEP: op_nxt = iod_pkg::IOD_OP_DIVIDE_STEP;
            `IOD_OP3_TADD:    op_nxt = iod_pkg::IOD_OP_TADD;
            `IOD_OP3_TSUB:    op_nxt = iod_pkg::IOD_OP_TSUB;
            `IOD_OP3_TADDTV:  op_nxt = iod_pkg::IOD_OP_TADD_TV;
            `IOD_OP3_TSUBTV:  op_nxt = iod_pkg::IOD_OP_TSUB_TV;
            `IOD_OP3_MULSTEP: op_nxt = iod_pkg::IOD_OP_MULTIPLY_STEP;
            `IOD_OP3_SHL:     op_nxt = iod_pkg::IOD_OP_SHIFT_LEFT_LOGICAL;
            `IOD_OP3_SHRL:    op_nxt = iod_pkg::IOD_OP_SHIFT_RIGHT_LOGICAL;
            `IOD_OP3_SHRA:    op_nxt = iod_pkg::IOD_OP_SHIFT_RIGHT_ARITH;
            `IOD_OP3_READ_ANCILLARY_STATE: begin
              // The rd test comes first: the barrier encoding wins over a Y read.
              if (rd_f == 5'h00) begin
                op_nxt    = iod_pkg::IOD_OP_STORE_BARRIER;
                unimp_nxt = 1'b1;
              end else if (rs1_f == 5'h00) begin
                op_nxt = iod_pkg::IOD_OP_READ_MULTIPLY_DIVIDE_REG;
              end else begin
                op_nxt = iod_pkg::IOD_OP_READ_ANCILLARY_STATE;
              end
            end
            `IOD_OP3_READ_PROCESSOR_STATE: op_nxt = iod_pkg::IOD_OP_READ_PROCESSOR_STATE;
            `IOD_OP3_READ_WINDOW_INVALID_MASK: op_nxt = iod_pkg::IOD_OP_READ_WINDOW_INVALID_MASK;
            `IOD_OP3_READ_TRAP_BASE: op_nxt = iod_pkg::IOD_OP_READ_TRAP_BASE;
            `IOD_OP3_SCAN:  op_nxt = iod_pkg::IOD_OP_BIT_SCAN;
            `IOD_OP3_WRITE_ANCILLARY_STATE: begin
              op_nxt = (rd_f == 5'h00) ? iod_pkg::IOD_OP_WRITE_MULTIPLY_DIVIDE_REG
                                       : iod_pkg::IOD_OP_WRITE_ANCILLARY_STATE;
            end
            `IOD_OP3_WRPSR: op_nxt = iod_pkg::IOD_OP_WRITE_PROCESSOR_STATE;
            `IOD_OP3_WRWIM: op_nxt = iod_pkg::IOD_OP_WRITE_WINDOW_INVALID_MASK;
            `IOD_OP3_WRTBR: op_nxt = iod_pkg::IOD_OP_WRITE_TRAP_BASE;
            `IOD_OP3_FPOP1: begin
              op_nxt    = iod_pkg::IOD_OP_FLOAT_OPERATE;
              opf_nxt   = opf;
              unimp_nxt = 1'b1;
            end
            `IOD_OP3_FPOP2: begin
              op_nxt    = iod_pkg::IOD_OP_FLOAT_COMPARE;
              opf_nxt   = opf;
              unimp_nxt = 1'b1;
            end
            `IOD_OP3_COPROC_OPERATE_ONE: begin
              op_nxt    = iod_pkg::IOD_OP_COPROC_OPERATE_ONE;
              unimp_nxt = 1'b1;
            end
            `IOD_OP3_CPOP2: begin
              op_nxt    = iod_pkg::IOD_OP_COPROC_OPERATE_TWO;
              unimp_nxt = 1'b1;
            end
            `IOD_OP3_JMPL:    op_nxt = iod_pkg::IOD_OP_JUMP_AND_LINK;
            `IOD_OP3_RETURN_FROM_TRAP:    op_nxt = iod_pkg::IOD_OP_RETURN_FROM_TRAP;
            `IOD_OP3_TICC:    op_nxt = iod_pkg::IOD_OP_TRAP_COND;
            `IOD_OP3_FLUSH: begin
              op_nxt    = iod_pkg::IOD_OP_FLUSH;
              unimp_nxt = 1'b1;
            end
            `IOD_OP3_SAVE:    op_nxt = iod_pkg::IOD_OP_SAVE;
            `IOD_OP3_RESTORE: op_nxt = iod_pkg::IOD_OP_RESTORE;
            default:          op_nxt = iod_pkg::IOD_OP_ILLEGAL;
          endcase
        end
        if (op3 == `IOD_OP3_DIVSTEP || op3 == `IOD_OP3_TADD || op3 == `IOD_OP3_TSUB ||
            op3 == `IOD_OP3_TADDTV || op3 == `IOD_OP3_TSUBTV ||
            op3 == `IOD_OP3_MULSTEP) begin
          set_cc_nxt = 1'b1;
        end
      end
      `IOD_FMT_MEM: begin
        op_nxt    = mem_op;
        alt_nxt   = mem_alt;
        unimp_nxt = mem_unimp;
      end
    endcase
    // Unknown encodings trap the same way as known unimplemented ones.
    if (op_nxt == iod_pkg::IOD_OP_ILLEGAL) begin
      unimp_nxt = 1'b1;
    end
    if (!valid_i) begin
      unimp_nxt = 1'b0;
    end
  end

  // One register stage keeps all data outputs glitch-free into execute.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_r  <= 1'b0;
      op_r     <= iod_pkg::IOD_OP_ILLEGAL;
      cond_r   <= 4'h0;
      set_cc_r <= 1'b0;
      alt_r    <= 1'b0;
      opf_r    <= 9'h000;
      disp_r   <= 30'h0000_0000;
      unimp_r  <= 1'b0;
    end else begin
      valid_r  <= valid_nxt;
      op_r     <= op_nxt;
      cond_r   <= cond_nxt;
      set_cc_r <= set_cc_nxt;
      alt_r    <= alt_nxt;
      opf_r    <= opf_nxt;
      disp_r   <= disp_nxt;
      unimp_r  <= unimp_nxt;
    end
  end

  assign valid_o     = valid_r;
  assign op_o        = op_r;
  assign cond_o      = cond_r;
  assign set_cc_o    = set_cc_r;
  assign alt_space_o = alt_r;
  assign fp_subop_o  = opf_r;
  assign call_disp_o = disp_r;
  assign unimp_o     = unimp_r;

endmodule : iod_decoder
`default_nettype wire

// File: iod_decoder_chk.sv
// Port-level assertions for the instruction decoder.
`timescale 1ns/1ps
`default_nettype none
`include "iod_cfg.svh"

module iod_decoder_chk (
  input wire logic              ref_clk_i,    // Core clock.
  input wire logic              resetn_i,     // Asynchronous reset, active low.
  input wire logic              valid_i,      // Word valid.
  input wire logic [31:0]       instr_i,      // Instruction word.
  input wire logic              valid_o,      // Result valid.
  input wire iod_pkg::iod_op_t  op_o,         // Operation class.
  input wire logic [3:0]        cond_o,       // Condition field.
  input wire logic              set_cc_o,     // Sets condition codes.
  input wire logic              alt_space_o,  // Alternate space access.
  input wire logic [8:0]        fp_subop_o,   // Floating sub-opcode.
  input wire logic [29:0]       call_disp_o,  // Call displacement.
  input wire logic              unimp_o       // Unimplemented trap request.
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [1:0] fmt;
  logic [5:0] op3;
  assign fmt = instr_i[31:30];
  assign op3 = instr_i[24:19];

  property p_sethi;
    valid_i && fmt == `IOD_FMT_BRANCH && op3[5:3] == `IOD_OP2_SETHI && instr_i[29:25] != 5'h00
      |=> op_o == iod_pkg::IOD_OP_SETHI && !unimp_o;
  endproperty
  a_sethi: assert property (p_sethi) else $error("sethi class wrong");
  property p_nop;
    valid_i && fmt == `IOD_FMT_BRANCH && op3[5:3] == `IOD_OP2_SETHI && instr_i[29:25] == 5'h00
      |=> op_o == iod_pkg::IOD_OP_NOP && !unimp_o;
  endproperty
  a_nop: assert property (p_nop) else $error("nop class wrong");
  property p_fbr;
    fmt == `IOD_FMT_BRANCH && op3[5:3] == `IOD_OP2_FBR
      |=> op_o == iod_pkg::IOD_OP_FBRANCH && cond_o == $past(instr_i[28:25]);
  endproperty
  a_fbr: assert property (p_fbr) else $error("float branch wrong");
  property p_cbr;
    valid_i && fmt == `IOD_FMT_BRANCH && op3[5:3] == `IOD_OP2_CBR
      |=> op_o == iod_pkg::IOD_OP_CBRANCH && unimp_o;
  endproperty
  a_cbr: assert property (p_cbr) else $error("coprocessor branch wrong");
  property p_call;
    valid_i && fmt == `IOD_FMT_CALL
      |=> op_o == iod_pkg::IOD_OP_CALL && call_disp_o == $past(instr_i[29:0]) && !unimp_o;
  endproperty
  a_call: assert property (p_call) else $error("call decode wrong");
  property p_div;
    valid_i && fmt == `IOD_FMT_ARITH && op3 inside {6'h0e, 6'h0f, 6'h1e, 6'h1f} |=> unimp_o;
  endproperty
  a_div: assert property (p_div) else $error("divide not flagged");
  property p_fpop;
    valid_i && fmt == `IOD_FMT_ARITH && op3[5:2] == 4'hd
      |=> unimp_o && fp_subop_o == ($past(op3[1]) ? 9'h000 : $past(instr_i[13:5]));
  endproperty
  a_fpop: assert property (p_fpop) else $error("float operate wrong");
  property p_store_barrier;
    valid_i && fmt == `IOD_FMT_ARITH && op3 == `IOD_OP3_READ_ANCILLARY_STATE && instr_i[29:25] == 5'h00
      |=> op_o == iod_pkg::IOD_OP_STORE_BARRIER && unimp_o;
  endproperty
  a_store_barrier: assert property (p_store_barrier) else $error("store barrier wrong");
  property p_trap;
    fmt == `IOD_FMT_ARITH && op3 == `IOD_OP3_TICC
      |=> op_o == iod_pkg::IOD_OP_TRAP_COND && cond_o == $past(instr_i[28:25]);
  endproperty
  a_trap: assert property (p_trap) else $error("trap condition wrong");
  property p_alt;
    fmt == `IOD_FMT_MEM && op3[5:4] == 2'h1 |=> alt_space_o;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate space missing");
  property p_illegal;
    valid_o && op_o == iod_pkg::IOD_OP_ILLEGAL |-> unimp_o;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal word not trapped");
  property p_gate;
    !valid_i |=> !unimp_o && !valid_o;
  endproperty
  a_gate: assert property (p_gate) else $error("trap without valid word");
endmodule : iod_decoder_chk

bind iod_decoder iod_decoder_chk u_chk (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .valid_i(valid_i), .instr_i(instr_i),
  .valid_o(valid_o), .op_o(op_o), .cond_o(cond_o), .set_cc_o(set_cc_o),
  .alt_space_o(alt_space_o), .fp_subop_o(fp_subop_o), .call_disp_o(call_disp_o),
  .unimp_o(unimp_o)
);
`default_nettype wire

// File: iod_fetch_model.sv
// Fetch stage model that feeds instruction words to the decoder.
`timescale 1ns/1ps
`default_nettype none

module iod_fetch_model (
  input  wire logic   ref_clk_i,  // Core clock.
  output logic        valid_o,    // Word valid.
  output logic [31:0] instr_o     // Instruction word.
);
  initial begin
    valid_o = 1'b0;
    instr_o = 32'h0000_0000;
  end
  // Presents one word from the next rising edge on and holds it.
  task automatic put(input logic [31:0] w, input logic v);
    @(posedge ref_clk_i);
    valid_o <= v;
    instr_o <= w;
  endtask : put
  // An idle fetch stage must not look like a repeat of the last word.
  task automatic idle();
    @(posedge ref_clk_i);
    valid_o <= 1'b0;
    instr_o <= ~instr_o;
  endtask : idle
endmodule : iod_fetch_model
`default_nettype wire

// File: iod_mem_class.sv
// Memory-format (format 11) opcode classifier.
`timescale 1ns/1ps
`default_nettype none
`include "iod_cfg.svh"

module iod_mem_class (
  input  wire logic [5:0]     op3_i,      // Operation field of the word.
  output iod_pkg::iod_op_t    op_o,       // Memory operation class.
  output logic                alt_o,      // Alternate address space form.
  output logic                unimp_o     // No hardware implementation.
);

  logic [3:0] base;

  always_comb begin
    base    = op3_i[3:0];
    alt_o   = 1'b0;
    unimp_o = 1'b0;
    op_o    = iod_pkg::IOD_OP_ILLEGAL;
    if (!op3_i[5]) begin
      // Bit 4 only selects the alternate space; the base code is shared.
      alt_o = op3_i[4];
      unique case (base[3:0])
        4'h0: op_o = iod_pkg::IOD_OP_LOAD_WORD;
        4'h1: op_o = iod_pkg::IOD_OP_LOAD_UBYTE;
        4'h2: op_o = iod_pkg::IOD_OP_LOAD_UHALF;
        4'h3: op_o = iod_pkg::IOD_OP_LOAD_DOUBLE;
        4'h4: op_o = iod_pkg::IOD_OP_STORE_WORD;
        4'h5: op_o = iod_pkg::IOD_OP_STORE_BYTE;
        4'h6: op_o = iod_pkg::IOD_OP_STORE_HALF;
        4'h7: op_o = iod_pkg::IOD_OP_STORE_DOUBLE;
        4'h9: op_o = iod_pkg::IOD_OP_LOAD_SBYTE;
        4'ha: op_o = iod_pkg::IOD_OP_LOAD_SHALF;
        4'hd: op_o = iod_pkg::IOD_OP_ATOMIC_LOAD_STORE_BYTE;
        4'hf: op_o = iod_pkg::IOD_OP_SWAP;
        default: op_o = iod_pkg::IOD_OP_ILLEGAL;
      endcase
    end else if (op3_i[4:3] == 2'h0) begin
      op_o    = iod_pkg::IOD_OP_FLOAT_MEM;
      unimp_o = 1'b1;
    end else if (op3_i[4:3] == 2'h2 && op3_i[2:0] != 3'h7) begin
      op_o    = iod_pkg::IOD_OP_COPROC_MEM;
      unimp_o = 1'b1;
    end
  end

endmodule : iod_mem_class
`default_nettype wire

// File: iod_pkg.sv
// Types shared by the instruction decoder files.
package iod_pkg;

  typedef enum logic [6:0] {
    IOD_OP_ILLEGAL,
    IOD_OP_UNIMP,
    IOD_OP_SETHI,
    IOD_OP_NOP,
    IOD_OP_BICC,
    IOD_OP_FBRANCH,
    IOD_OP_CBRANCH,
    IOD_OP_CALL,
    IOD_OP_ADD,
    IOD_OP_AND,
    IOD_OP_OR,
    IOD_OP_XOR,
    IOD_OP_SUB,
    IOD_OP_ANDN,
    IOD_OP_ORN,
    IOD_OP_XNOR,
    IOD_OP_ADDX,
    IOD_OP_SUBX,
    IOD_OP_UNSIGNED_MULTIPLY,
    IOD_OP_SIGNED_MULTIPLY,
    IOD_OP_UDIV,
    IOD_OP_SDIV,
    IOD_OP_DIVIDE_STEP,
    IOD_OP_TADD,
    IOD_OP_TSUB,
    IOD_OP_TADD_TV,
    IOD_OP_TSUB_TV,
    IOD_OP_MULTIPLY_STEP,
    IOD_OP_SHIFT_LEFT_LOGICAL,
    IOD_OP_SHIFT_RIGHT_LOGICAL,
    IOD_OP_SHIFT_RIGHT_ARITH,
    IOD_OP_READ_ANCILLARY_STATE,
    IOD_OP_READ_MULTIPLY_DIVIDE_REG,
    IOD_OP_STORE_BARRIER,
    IOD_OP_READ_PROCESSOR_STATE,
    IOD_OP_READ_WINDOW_INVALID_MASK,
    IOD_OP_READ_TRAP_BASE,
    IOD_OP_BIT_SCAN,
    IOD_OP_WRITE_ANCILLARY_STATE,
    IOD_OP_WRITE_MULTIPLY_DIVIDE_REG,
    IOD_OP_WRITE_PROCESSOR_STATE,
    IOD_OP_WRITE_WINDOW_INVALID_MASK,
    IOD_OP_WRITE_TRAP_BASE,
    IOD_OP_FLOAT_OPERATE,
    IOD_OP_FLOAT_COMPARE,
    IOD_OP_COPROC_OPERATE_ONE,
    IOD_OP_COPROC_OPERATE_TWO,
    IOD_OP_JUMP_AND_LINK,
    IOD_OP_RETURN_FROM_TRAP,
    IOD_OP_TRAP_COND,
    IOD_OP_FLUSH,
    IOD_OP_SAVE,
    IOD_OP_RESTORE,
    IOD_OP_LOAD_WORD,
    IOD_OP_LOAD_UBYTE,
    IOD_OP_LOAD_UHALF,
    IOD_OP_LOAD_DOUBLE,
    IOD_OP_STORE_WORD,
    IOD_OP_STORE_BYTE,
    IOD_OP_STORE_HALF,
    IOD_OP_STORE_DOUBLE,
    IOD_OP_LOAD_SBYTE,
    IOD_OP_LOAD_SHALF,
    IOD_OP_ATOMIC_LOAD_STORE_BYTE,
    IOD_OP_SWAP,
    IOD_OP_FLOAT_MEM,
    IOD_OP_COPROC_MEM
  } iod_op_t;

endpackage : iod_pkg
